// file: inc/pcg_pkg.sv
// pcg_pkg: shared constants for the card-socket glue and the controller front end.
// assumes both ends and the bench share one 25 MHz clock (clk_i).
`default_nettype none
package pcg_pkg;
    // clock and timing
    localparam int CLK_NS = 40;
    localparam int ARB_NS = 120; // internal arbitration time of the controller
    localparam int ARB_CYC = (ARB_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [1:0] ARB_CYC_W = 2'(ARB_CYC);
    // controller address map
    localparam logic [15:0] MEM_BYTES = 16'hA000; // 40K byte display buffer
    localparam logic [15:0] REG_BASE = 16'hFFE0; // register_set_first, 32 bytes above
    localparam int MEM_WORDS = 20480;
    localparam int REG_WORDS = 16;
    localparam int REG_PANEL_EN_BIT = 0; // register_set_first bit driving panel power
    // strap layout
    localparam int STRAP_MODE_LSB = 0; // config_straps[2:0]
    localparam int STRAP_BYTE_ORDER = 3; // byte_order_strap
    localparam int STRAP_POWER_POL = 4; // panel_power_polarity_strap
    localparam logic [2:0] MODE_SH_A = 3'h0;
    localparam logic [2:0] MODE_SH_B = 3'h1;
    localparam logic [2:0] MODE_68K_A = 3'h3;
    localparam logic [2:0] MODE_68K_B = 3'h5;
    localparam logic [2:0] MODE_GENERIC = 3'h7;
    typedef enum logic [2:0] {
        PCG_BUS_SH_A = 3'b000,
        PCG_BUS_SH_B = 3'b001,
        PCG_BUS_68K_A = 3'b010,
        PCG_BUS_68K_B = 3'b011,
        PCG_BUS_GEN_CS = 3'b100,
        PCG_BUS_GEN_SHARED = 3'b101,
        PCG_BUS_RESERVED = 3'b110
    } pcg_bus_mode_t;
    // apb register map of the glue end
    localparam logic [7:0] APB_CTRL = 8'h00;
    localparam logic [7:0] APB_ADDR = 8'h04;
    localparam logic [7:0] APB_WDATA = 8'h08;
    localparam logic [7:0] APB_STATUS = 8'h0C;
    localparam logic [7:0] APB_RDATA = 8'h10;
    localparam logic [7:0] APB_STRAP = 8'h14;
    localparam int CTRL_START = 0;
    localparam int CTRL_WRITE = 1;
    localparam int CTRL_BE_LO = 2;
    localparam int CTRL_BE_HI = 3;
    localparam int CTRL_CARD_RESET = 4;
    localparam int CTRL_FULL_DECODE = 5;
    localparam logic [4:0] STRAP_RESET = 5'h07; // generic mode, little endian, low power pin
    localparam logic [9:0] ALIAS_BASE = 10'h000; // upper block matched under full decode
endpackage : pcg_pkg
`default_nettype wire

// file: inc/pcg_if.sv
// pcg_if: controller pins between the socket glue and the controller front end.
// assumes both ends run on the same clock; the data bus level is resolved here.
`timescale 1ns/1ps
`default_nettype none
interface pcg_if;
    logic [15:0] controller_address_in;
    logic [15:0] host_data;
    logic host_data_oe;
    logic [15:0] dev_data;
    logic dev_data_oe;
    logic [15:0] controller_data_bus;
    logic cs_n;
    logic low_byte_read_n;
    logic high_byte_read_n;
    logic low_byte_write_n;
    logic high_byte_write_n;
    logic controller_reset_n;
    logic bus_start_strap;
    logic [4:0] config_straps;
    logic wait_n;
    // bus level: controller drive wins over host drive, undriven reads as zero
    assign controller_data_bus = dev_data_oe ? dev_data : (host_data_oe ? host_data : 16'h0000);
    modport glue (
        output controller_address_in, host_data, host_data_oe, cs_n,
        output low_byte_read_n, high_byte_read_n, low_byte_write_n, high_byte_write_n,
        output controller_reset_n, bus_start_strap, config_straps,
        input controller_data_bus, wait_n
    );
    modport ctrl (
        input controller_address_in, controller_data_bus, cs_n,
        input low_byte_read_n, high_byte_read_n, low_byte_write_n, high_byte_write_n,
        input controller_reset_n, bus_start_strap, config_straps,
        output dev_data, dev_data_oe, wait_n
    );
endinterface : pcg_if
`default_nettype wire

// file: design/pcg_ctrl.sv
// pcg_ctrl: controller front end in generic chip-select mode with its memory and registers.
// assumes the bus clock is clk_i and the glue keeps to the strobe decode.
`timescale 1ns/1ps
`default_nettype none
module pcg_ctrl (
    input wire logic clk_i, // bus clock, also the input clock
    input wire logic rst_i, // power-on reset, sync, active high
    pcg_if.ctrl bus, // controller pins
    output logic panel_power_out_o, // panel power pin
    output logic [2:0] bus_mode_o // decoded bus mode
);
    typedef enum logic [1:0] {
        PCG_IDLE = 2'b00,
        PCG_BUSY = 2'b01,
        PCG_DONE = 2'b10
    } pcg_acc_t;
    logic [15:0] mem_q [pcg_pkg::MEM_WORDS];
    logic [15:0] reg_q [pcg_pkg::REG_WORDS];
    logic [4:0] strap_q;
    logic bs_q;
    logic rstn_prev_q;
    logic [1:0] cnt_q;
    logic [15:0] dout_q;
    pcg_acc_t st_q;
    pcg_pkg::pcg_bus_mode_t mode;
    logic in_reset, mode_ok, access, swap, rd_lo, rd_hi, wr_lo, wr_hi;
    logic in_mem, in_reg;
    logic [15:0] wd, rdw;
    logic [14:0] widx;

    // catch the straps at the rising edge of the controller reset
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rstn_prev_q <= 1'b0;
            strap_q <= pcg_pkg::STRAP_RESET;
            bs_q <= 1'b0;
        end else begin
            rstn_prev_q <= bus.controller_reset_n;
            if (!rstn_prev_q && bus.controller_reset_n) begin
                strap_q <= bus.config_straps;
                bs_q <= bus.bus_start_strap;
            end
        end
    end

    // mode decode from the latched straps
    always_comb begin
        case (strap_q[2:0])
            pcg_pkg::MODE_SH_A: mode = pcg_pkg::PCG_BUS_SH_A;
            pcg_pkg::MODE_SH_B: mode = pcg_pkg::PCG_BUS_SH_B;
            pcg_pkg::MODE_68K_A: mode = pcg_pkg::PCG_BUS_68K_A;
            pcg_pkg::MODE_68K_B: mode = pcg_pkg::PCG_BUS_68K_B;
            pcg_pkg::MODE_GENERIC: begin
                mode = bs_q ? pcg_pkg::PCG_BUS_GEN_SHARED : pcg_pkg::PCG_BUS_GEN_CS;
            end
            default: mode = pcg_pkg::PCG_BUS_RESERVED;
        endcase
    end

    // only the chip-select mode is served here; bus-start is not looked at during cycles
    assign in_reset = rst_i || !bus.controller_reset_n;
    assign mode_ok = (mode == pcg_pkg::PCG_BUS_GEN_CS);
    assign swap = strap_q[pcg_pkg::STRAP_BYTE_ORDER];
    // big endian swaps the byte lanes, strobes included
    assign rd_lo = swap ? !bus.high_byte_read_n : !bus.low_byte_read_n;
    assign rd_hi = swap ? !bus.low_byte_read_n : !bus.high_byte_read_n;
    assign wr_lo = swap ? !bus.high_byte_write_n : !bus.low_byte_write_n;
    assign wr_hi = swap ? !bus.low_byte_write_n : !bus.high_byte_write_n;
    assign wd = swap ? {bus.controller_data_bus[7:0], bus.controller_data_bus[15:8]}
                     : bus.controller_data_bus;
    assign access = mode_ok && !bus.cs_n && (rd_lo || rd_hi || wr_lo || wr_hi);
    assign in_mem = bus.controller_address_in < pcg_pkg::MEM_BYTES;
    assign in_reg = bus.controller_address_in >= pcg_pkg::REG_BASE;
    assign widx = bus.controller_address_in[15:1];
    assign rdw = in_mem ? mem_q[widx] : (in_reg ? reg_q[widx[3:0]] : 16'h0000);

    // access sequencer: arbitration delay, then the transfer, then wait for release
    always_ff @(posedge clk_i) begin
        if (in_reset) begin
            st_q <= PCG_IDLE;
            cnt_q <= 2'h0;
        end else begin
            case (st_q)
                PCG_IDLE: begin
                    cnt_q <= 2'h0;
                    if (access) st_q <= PCG_BUSY;
                end
                PCG_BUSY: begin
                    cnt_q <= cnt_q + 2'h1;
                    if (!access) st_q <= PCG_IDLE;
                    else if (cnt_q == pcg_pkg::ARB_CYC_W - 2'h1) st_q <= PCG_DONE;
                end
                PCG_DONE: if (!access) st_q <= PCG_IDLE;
                default: st_q <= PCG_IDLE;
            endcase
        end
    end

    // writes land and read data is taken as arbitration completes
    always_ff @(posedge clk_i) begin
        if (st_q == PCG_BUSY && access && cnt_q == pcg_pkg::ARB_CYC_W - 2'h1) begin
            if (in_mem && wr_lo) mem_q[widx][7:0] <= wd[7:0];
            if (in_mem && wr_hi) mem_q[widx][15:8] <= wd[15:8];
        end
    end

    always_ff @(posedge clk_i) begin
        if (in_reset) begin
            for (int i = 0; i < pcg_pkg::REG_WORDS; i++) reg_q[i] <= 16'h0000;
            dout_q <= 16'h0000;
        end else if (st_q == PCG_BUSY && access && cnt_q == pcg_pkg::ARB_CYC_W - 2'h1) begin
            if (in_reg && wr_lo) reg_q[widx[3:0]][7:0] <= wd[7:0];
            if (in_reg && wr_hi) reg_q[widx[3:0]][15:8] <= wd[15:8];
            dout_q <= swap ? {rdw[7:0], rdw[15:8]} : rdw;
        end
    end

    // wait is low from the first strobe until the transfer is done
    assign bus.wait_n = !(access && st_q != PCG_DONE);
    assign bus.dev_data = dout_q;
    assign bus.dev_data_oe = access && (rd_lo || rd_hi) && st_q == PCG_DONE;
    // panel power polarity from the strap, enable from the first register
    assign panel_power_out_o = strap_q[pcg_pkg::STRAP_POWER_POL]
                               ? reg_q[0][pcg_pkg::REG_PANEL_EN_BIT]
                               : !reg_q[0][pcg_pkg::REG_PANEL_EN_BIT];
    assign bus_mode_o = mode;
endmodule : pcg_ctrl
`default_nettype wire

// file: design/pcg_glue.sv
// pcg_glue: card-socket host with its decode glue; software drives it over apb.
// assumes the controller front end shares clk_i as its bus clock.
// Function
// - derive byte read/write strobes and chip select
// - controller reset is inverted card reset
// - address and data lines wired straight through
// - system supplies a free bus clock
// - bus-start strap held low
// - controller latches straps at reset release
// - byte-order strap picks endianness
// - polarity strap sets panel power level
// - bus-mode strap code table
// - low write: write, first enable, attribute high
// - high write: write, second enable, attribute high
// - low read: output enable, first enable, attribute high
// - high read: output enable, second enable, attribute high
// - chip select: attribute high and any strobe
// - registers in top 32 bytes of block
// - 40K display buffer in the window
// - upper address bits ignored, 1024 aliases
// - optional full decode of upper bits
// - cycle starts with card enables, attribute inactive
// - controller holds wait until transfer done
//
// Design decision made here: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module pcg_glue (
    input wire logic clk_i, // system clock, also the controller bus clock
    input wire logic rst_i, // sync reset, active high
    input wire logic psel, // apb select
    input wire logic penable, // apb enable
    input wire logic pwrite, // apb direction
    input wire logic [7:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error
    pcg_if.glue bus // controller pins
);
    typedef enum logic [1:0] {
        PCG_C_IDLE = 2'b00,
        PCG_C_SETUP = 2'b01,
        PCG_C_STROBE = 2'b10,
        PCG_C_HOLD = 2'b11
    } pcg_cyc_t;
    pcg_cyc_t st_q;
    logic [5:1] ctrl_q;
    logic [25:0] addr_q;
    logic [15:0] wdata_q;
    logic [15:0] rdata_q;
    logic [4:0] strap_q;
    logic ce1_n_q, ce2_n_q, oe_n_q, we_n_q, doe_q;
    logic reg_n;
    logic apb_wr, start, decode_ok;
    logic we_lo_n, we_hi_n, rd_lo_n, rd_hi_n;

    assign apb_wr = psel && penable && pwrite;
    assign start = apb_wr && paddr == pcg_pkg::APB_CTRL && pwdata[pcg_pkg::CTRL_START]
                   && st_q == PCG_C_IDLE;
    // attribute space is never used by this host
    assign reg_n = 1'b1;

    // software registers; a start while a cycle runs is dropped
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_q <= 5'h0E; // card reset held, both bytes enabled
            addr_q <= 26'h0000000;
            wdata_q <= 16'h0000;
            strap_q <= pcg_pkg::STRAP_RESET;
        end else if (apb_wr) begin
            case (paddr)
                pcg_pkg::APB_CTRL: ctrl_q <= pwdata[5:1];
                pcg_pkg::APB_ADDR: addr_q <= pwdata[25:0];
                pcg_pkg::APB_WDATA: wdata_q <= pwdata[15:0];
                pcg_pkg::APB_STRAP: strap_q <= pwdata[4:0];
                default: ;
            endcase
        end
    end

    // apb answers in the access phase with no wait states
    always_comb begin
        case (paddr)
            pcg_pkg::APB_CTRL: prdata = {26'h0000000, ctrl_q, 1'b0};
            pcg_pkg::APB_ADDR: prdata = {6'h00, addr_q};
            pcg_pkg::APB_WDATA: prdata = {16'h0000, wdata_q};
            pcg_pkg::APB_STATUS: prdata = {29'h00000000, bus.wait_n, 1'b0, st_q != PCG_C_IDLE};
            pcg_pkg::APB_RDATA: prdata = {16'h0000, rdata_q};
            pcg_pkg::APB_STRAP: prdata = {27'h0000000, strap_q};
            default: prdata = 32'h00000000;
        endcase
    end
    assign pready = 1'b1;
    assign pslverr = 1'b0;

    // card memory cycle: enables, then strobe until wait releases, then release
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_q <= PCG_C_IDLE;
            ce1_n_q <= 1'b1;
            ce2_n_q <= 1'b1;
            oe_n_q <= 1'b1;
            we_n_q <= 1'b1;
            doe_q <= 1'b0;
            rdata_q <= 16'h0000;
        end else begin
            case (st_q)
                PCG_C_IDLE: begin
                    if (start) begin
                        ce1_n_q <= !pwdata[pcg_pkg::CTRL_BE_LO];
                        ce2_n_q <= !pwdata[pcg_pkg::CTRL_BE_HI];
                        st_q <= PCG_C_SETUP;
                    end
                end
                PCG_C_SETUP: begin
                    oe_n_q <= ctrl_q[pcg_pkg::CTRL_WRITE];
                    we_n_q <= !ctrl_q[pcg_pkg::CTRL_WRITE];
                    doe_q <= ctrl_q[pcg_pkg::CTRL_WRITE];
                    st_q <= PCG_C_STROBE;
                end
                PCG_C_STROBE: begin
                    // a deselected or foreign-mode controller never pulls wait
                    if (bus.wait_n) begin
                        if (!oe_n_q) rdata_q <= bus.controller_data_bus;
                        oe_n_q <= 1'b1;
                        we_n_q <= 1'b1;
                        st_q <= PCG_C_HOLD;
                    end
                end
                PCG_C_HOLD: begin
                    ce1_n_q <= 1'b1;
                    ce2_n_q <= 1'b1;
                    doe_q <= 1'b0;
                    st_q <= PCG_C_IDLE;
                end
                default: st_q <= PCG_C_IDLE;
            endcase
        end
    end

    // strobe decode; pure gates so strobes track the card lines in the same cycle
    assign we_lo_n = !(!we_n_q && !ce1_n_q && reg_n);
    assign we_hi_n = !(!we_n_q && !ce2_n_q && reg_n);
    assign rd_lo_n = !(!oe_n_q && !ce1_n_q && reg_n);
    assign rd_hi_n = !(!oe_n_q && !ce2_n_q && reg_n);
    // with full decode off the upper bits are ignored and the controller aliases
    assign decode_ok = !ctrl_q[pcg_pkg::CTRL_FULL_DECODE]
                       || addr_q[25:16] == pcg_pkg::ALIAS_BASE;
    assign bus.cs_n = !(reg_n && decode_ok
                        && (!rd_lo_n || !rd_hi_n || !we_lo_n || !we_hi_n));
    assign bus.low_byte_write_n = we_lo_n;
    assign bus.high_byte_write_n = we_hi_n;
    assign bus.low_byte_read_n = rd_lo_n;
    assign bus.high_byte_read_n = rd_hi_n;
    assign bus.controller_reset_n = !ctrl_q[pcg_pkg::CTRL_CARD_RESET];
    assign bus.controller_address_in = addr_q[15:0];
    assign bus.host_data = wdata_q;
    assign bus.host_data_oe = doe_q;
    // bus clock is clk_i itself, shared with the controller; no divider needed
    assign bus.bus_start_strap = 1'b0;
    assign bus.config_straps = strap_q;
endmodule : pcg_glue
`default_nettype wire

// file: verification/pcg_checker.sv
// pcg_checker: concurrent checks on the controller pins between glue and controller.
// assumes one clock domain (clk_i) and sync active-high rst_i shared by both ends.
`timescale 1ns/1ps
`default_nettype none
module pcg_checker (
    input wire logic clk_i, // shared clock
    input wire logic rst_i, // sync reset, active high
    input wire logic cs_n, // chip select
    input wire logic low_byte_read_n, // low read strobe
    input wire logic high_byte_read_n, // high read strobe
    input wire logic low_byte_write_n, // low write strobe
    input wire logic high_byte_write_n, // high write strobe
    input wire logic wait_n, // controller wait
    input wire logic bus_start_strap, // bus-start strap
    input wire logic [4:0] config_straps, // strap pins
    input wire logic controller_reset_n, // controller reset
    input wire logic [15:0] controller_address_in, // address pins
    input wire logic [15:0] host_data, // host write data
    input wire logic host_data_oe, // host drives data
    input wire logic dev_data_oe // controller drives data
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // writes in [3:2], reads in [1:0]
    wire logic [3:0] strb_n = {high_byte_write_n, low_byte_write_n, high_byte_read_n,
        low_byte_read_n};
    // a stall is the window where the host must hold everything still
    sequence s_stall;
        !cs_n && !wait_n;
    endsequence
    sequence s_wr_stall;
        s_stall ##0 (strb_n[3:2] != 2'b11);
    endsequence
    property p_cs_any; !cs_n |-> strb_n != 4'hF; endproperty
    property p_rw_excl; strb_n[3:2] != 2'b11 |-> strb_n[1:0] == 2'b11; endproperty
    property p_bs_low; bus_start_strap == 1'b0; endproperty
    property p_wait_sel; !wait_n |-> !cs_n; endproperty
    // arbitration is 3 cycles, so a stall far past that means a stuck controller
    property p_wait_end; $fell(wait_n) |-> ##[1:6] wait_n; endproperty
    property p_hold; s_stall |=> $stable(strb_n) && $stable(controller_address_in); endproperty
    property p_oe_excl; !(dev_data_oe && host_data_oe); endproperty
    property p_dev_oe; dev_data_oe |-> !cs_n && strb_n[1:0] != 2'b11; endproperty
    property p_wdata; s_wr_stall |-> host_data_oe ##1 $stable(host_data); endproperty
    property p_strap; $rose(controller_reset_n) |-> $stable(config_straps); endproperty
    a_cs_any: assert property (p_cs_any) else $error("cs low with no strobe");
    a_rw_excl: assert property (p_rw_excl) else $error("read and write strobes together");
    a_bs_low: assert property (p_bs_low) else $error("bus start strap not low");
    a_wait_sel: assert property (p_wait_sel) else $error("wait low while unselected");
    a_wait_end: assert property (p_wait_end) else $error("wait held too long");
    a_hold: assert property (p_hold) else $error("strobes or address moved in stall");
    a_oe_excl: assert property (p_oe_excl) else $error("data bus driven by both");
    a_dev_oe: assert property (p_dev_oe) else $error("read data without read strobe");
    a_wdata: assert property (p_wdata) else $error("write data not held");
    a_strap: assert property (p_strap) else $error("straps moved at reset release");
endmodule : pcg_checker
`default_nettype wire

// file: verification/pccard_host_glue_tb.sv
// pccard_host_glue_tb: drives the glue over apb and checks card cycles end to end.
// assumes pcg_glue and pcg_ctrl share clk_i and meet in pcg_if.
`timescale 1ns/1ps
`default_nettype none
module pccard_host_glue_tb;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic panel_pwr;
    logic [2:0] bus_mode;
    logic [31:0] rv;
    logic [15:0] cv;
    int n_mismatch = 0;
    int check_count = 0;
    int cyc = 0;
    logic [2:0] mcode [6] = '{pcg_pkg::MODE_SH_A, pcg_pkg::MODE_SH_B, pcg_pkg::MODE_68K_A,
        pcg_pkg::MODE_68K_B, pcg_pkg::MODE_GENERIC, 3'h2};
    pcg_pkg::pcg_bus_mode_t mexp [6] = '{pcg_pkg::PCG_BUS_SH_A, pcg_pkg::PCG_BUS_SH_B,
        pcg_pkg::PCG_BUS_68K_A, pcg_pkg::PCG_BUS_68K_B, pcg_pkg::PCG_BUS_GEN_CS,
        pcg_pkg::PCG_BUS_RESERVED};
    pcg_if bus_if ();
    pcg_glue u_pcg_glue (.clk_i(clk_i), .rst_i(rst_i), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .bus(bus_if));
    pcg_ctrl u_pcg_ctrl (.clk_i(clk_i), .rst_i(rst_i), .bus(bus_if),
        .panel_power_out_o(panel_pwr), .bus_mode_o(bus_mode));
    pcg_checker u_pcg_checker (.clk_i(clk_i), .rst_i(rst_i), .cs_n(bus_if.cs_n),
        .low_byte_read_n(bus_if.low_byte_read_n), .high_byte_read_n(bus_if.high_byte_read_n),
        .low_byte_write_n(bus_if.low_byte_write_n),
        .high_byte_write_n(bus_if.high_byte_write_n), .wait_n(bus_if.wait_n),
        .bus_start_strap(bus_if.bus_start_strap), .config_straps(bus_if.config_straps),
        .controller_reset_n(bus_if.controller_reset_n),
        .controller_address_in(bus_if.controller_address_in), .host_data(bus_if.host_data),
        .host_data_oe(bus_if.host_data_oe), .dev_data_oe(bus_if.dev_data_oe));
    // free-running 25 MHz clock
    initial begin
        forever #20 clk_i = ~clk_i;
    end
    // one apb transfer; an idle edge after it keeps back-to-back calls race free
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_i);
        penable <= 1'b1;
        @(posedge clk_i);
        while (pready !== 1'b1) @(posedge clk_i);
        rv = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_i);
    endtask : apb
    // one card memory cycle; read data of the last read cycle lands in cv
    task automatic card(input logic [25:0] a, input logic w, input logic [1:0] be,
        input logic fd, input logic [15:0] d);
        apb(1'b1, pcg_pkg::APB_ADDR, {6'h00, a});
        apb(1'b1, pcg_pkg::APB_WDATA, {16'h0000, d});
        apb(1'b1, pcg_pkg::APB_CTRL, {26'h0, fd, 1'b0, be, w, 1'b1});
        apb(1'b0, pcg_pkg::APB_STATUS, 32'h0);
        while (rv[0] !== 1'b0) apb(1'b0, pcg_pkg::APB_STATUS, 32'h0);
        apb(1'b0, pcg_pkg::APB_RDATA, 32'h0);
        cv = rv[15:0];
    endtask : card
    // straps only take effect through a controller reset pulse
    task automatic strap(input logic [4:0] s);
        apb(1'b1, pcg_pkg::APB_CTRL, 32'h0000_001C);
        apb(1'b1, pcg_pkg::APB_STRAP, {27'h0, s});
        apb(1'b1, pcg_pkg::APB_CTRL, 32'h0000_000C);
        repeat (2) @(posedge clk_i);
    endtask : strap
    task automatic cmp_w(input logic [31:0] g, input logic [31:0] e);
        check_count++;
        if (g !== e) begin
            n_mismatch++;
            $display("BAD %0t word got %h exp %h", $time, g, e);
        end
    endtask : cmp_w
    task automatic cmp_pin(input logic [2:0] g, input logic [2:0] e);
        check_count++;
        if (g !== e) begin
            n_mismatch++;
            $display("BAD %0t pin got %h exp %h", $time, g, e);
        end
    endtask : cmp_pin
    task automatic finish_test();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : finish_test
    // hang guard, far above the several hundred cycles the tests need
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            finish_test();
        end
    end
    initial begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        apb(1'b0, pcg_pkg::APB_STRAP, 32'h0);
        cmp_w(rv, 32'h0000_0007);
        cmp_pin({2'b00, bus_if.controller_reset_n}, 3'h0);
        cmp_pin({2'b00, bus_if.bus_start_strap}, 3'h0);
        apb(1'b1, 8'h18, 32'hFFFF_FFFF);
        apb(1'b0, 8'h18, 32'h0);
        cmp_w(rv, 32'h0);
        $display("test reset done");
        for (int i = 0; i < 6; i++) begin
            strap({2'b00, mcode[i]});
            cmp_pin(bus_mode, mexp[i]);
            cmp_pin({2'b00, bus_if.controller_reset_n}, 3'h1);
        end
        // reserved mode: controller must not answer
        card(26'h10, 1'b0, 2'b11, 1'b0, 16'h0);
        cmp_w({16'h0, cv}, 32'h0);
        $display("test modes done");
        for (int p = 1; p >= 0; p--) begin
            strap({p[0], p[0], 3'h7});
            cmp_pin({2'b00, panel_pwr}, {2'b00, ~p[0]});
            // big endian carries the even register byte in the upper lane
            card(26'h0FFE0, 1'b1, 2'b11, 1'b0, p[0] ? 16'h0100 : 16'h0001);
            cmp_pin({2'b00, panel_pwr}, {2'b00, p[0]});
            card(26'h0FFE0, 1'b0, 2'b11, 1'b0, 16'h0);
            cmp_w({16'h0, cv}, p[0] ? 32'h0000_0100 : 32'h0000_0001);
            // a word left by the big endian pass reads back byte swapped
            card(26'h00040, 1'b0, 2'b11, 1'b0, 16'h0);
            if (p == 0) cmp_w({16'h0, cv}, 32'h0000_3412);
            card(26'h00040, 1'b1, 2'b11, 1'b0, 16'h1234);
            card(26'h00040, 1'b0, 2'b11, 1'b0, 16'h0);
            cmp_w({16'h0, cv}, 32'h1234);
        end
        $display("test straps done");
        card(26'h00020, 1'b1, 2'b11, 1'b0, 16'h1111);
        card(26'h00020, 1'b1, 2'b01, 1'b0, 16'h22EE);
        card(26'h00020, 1'b0, 2'b11, 1'b0, 16'h0);
        cmp_w({16'h0, cv}, 32'h11EE);
        card(26'h00020, 1'b1, 2'b10, 1'b0, 16'h3377);
        card(26'h00020, 1'b0, 2'b11, 1'b0, 16'h0);
        cmp_w({16'h0, cv}, 32'h33EE);
        card(26'h09FFE, 1'b1, 2'b11, 1'b0, 16'h5AA5);
        card(26'h09FFE, 1'b0, 2'b11, 1'b0, 16'h0);
        cmp_w({16'h0, cv}, 32'h5AA5);
        card(26'h0A000, 1'b1, 2'b11, 1'b0, 16'h1234);
        card(26'h0A000, 1'b0, 2'b11, 1'b0, 16'h0);
        cmp_w({16'h0, cv}, 32'h0);
        $display("test memory done");
        card(26'h3_0030, 1'b1, 2'b11, 1'b0, 16'hBEEF);
        card(26'h0_0030, 1'b0, 2'b11, 1'b0, 16'h0);
        cmp_w({16'h0, cv}, 32'hBEEF);
        card(26'h1_0030, 1'b0, 2'b11, 1'b1, 16'h0);
        cmp_w({16'h0, cv}, 32'h0);
        card(26'h0_0030, 1'b0, 2'b11, 1'b1, 16'h0);
        cmp_w({16'h0, cv}, 32'hBEEF);
        $display("test alias done");
        finish_test();
    end
endmodule : pccard_host_glue_tb
`default_nettype wire
